// ==== dv/usb_line_partner.sv ====
`include "usb_swap_params.svh"

module usb_line_partner (
    // Hub pin drive
    input wire logic [`PIN_PAIRS-1:0] hub_plus_i,
    input wire logic [`PIN_PAIRS-1:0] hub_plus_oe_i,
    input wire logic [`PIN_PAIRS-1:0] hub_minus_i,
    input wire logic [`PIN_PAIRS-1:0] hub_minus_oe_i,
    // Far-end drive
    input wire logic [`PIN_PAIRS-1:0] far_plus_i,
    input wire logic [`PIN_PAIRS-1:0] far_minus_i,
    input wire logic [`PIN_PAIRS-1:0] far_oe_i,
    // Resolved line levels
    output logic [`PIN_PAIRS-1:0] plus_wire_o,
    output logic [`PIN_PAIRS-1:0] minus_wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released line follows the far end's drive, or reads low when the far end is not driving, instead of keeping its last level.
    assign plus_wire_o = (hub_plus_oe_i & hub_plus_i) | (~hub_plus_oe_i & far_oe_i & far_plus_i);
    assign minus_wire_o = (hub_minus_oe_i & hub_minus_i) | (~hub_minus_oe_i & far_oe_i & far_minus_i);
endmodule

// ==== dv/usb_port_swap_remap_config_test.sv ====
`include "usb_swap_params.svh"

module usb_port_swap_remap_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    import usb_swap_pkg::*;
    logic ref_clk_i, rst_n_i, cfg_wr_i, logical_mapping_enable_i, port3_enabled_i;
    cfg_byte_t cfg_addr_i, cfg_wdata_i, cfg_rdata_o, port_one_two_map_field_o, map;
    logic port1_enabled_o, port2_enabled_o, map_illegal_o;
    logical_num_t port1_logical_o, port2_logical_o;
    logic [1:0] port_count_o;
    logic [3:0] pin_exchange_bits_o, dpos_out_i, dpos_oe_i, dneg_out_i, dneg_oe_i, exch;
    logic [3:0] dpos_in_o, dneg_in_o, plus_pin_i, plus_pin_o, plus_pin_oe_o;
    logic [3:0] minus_pin_i, minus_pin_o, minus_pin_oe_o, far_p, far_m, far_oe;
    int err_total, samples_checked, cycles, seed;
    logic [2:0] sel_q[$];
    logic [15:0] exp_q[$];
    logic [2:0] mon_sel;
    logic [15:0] mon_exp;
    event sample_ev;
    cfg_byte_t adr[4] = '{8'hFA, 8'hFC, 8'hFA, 8'h7F};
    cfg_byte_t maps[8] = '{8'h21, 8'h12, 8'h01, 8'h10, 8'h00, 8'h32, 8'h04, 8'hF3};

    usb_port_swap_remap_config DUT (.ref_clk_i, .rst_n_i, .cfg_addr_i, .cfg_wr_i, .cfg_wdata_i,
        .cfg_rdata_o, .logical_mapping_enable_i, .port3_enabled_i, .port1_enabled_o,
        .port1_logical_o, .port2_enabled_o, .port2_logical_o, .map_illegal_o, .port_count_o,
        .pin_exchange_bits_o, .port_one_two_map_field_o, .dpos_out_i, .dpos_oe_i, .dneg_out_i,
        .dneg_oe_i, .dpos_in_o, .dneg_in_o, .plus_pin_i, .plus_pin_o, .plus_pin_oe_o,
        .minus_pin_i, .minus_pin_o, .minus_pin_oe_o);
    usb_line_partner far_end (.hub_plus_i(plus_pin_o), .hub_plus_oe_i(plus_pin_oe_o),
        .hub_minus_i(minus_pin_o), .hub_minus_oe_i(minus_pin_oe_o), .far_plus_i(far_p),
        .far_minus_i(far_m), .far_oe_i(far_oe), .plus_wire_o(plus_pin_i),
        .minus_wire_o(minus_pin_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [15:0] observe(input logic [2:0] sel);
        case (sel)
            3'h0: return {12'h000, pin_exchange_bits_o};
            3'h1: return {8'h00, port_one_two_map_field_o};
            3'h2: return {8'h00, cfg_rdata_o};
            3'h3: return {7'h00, port1_enabled_o, port1_logical_o, port2_enabled_o,
                port2_logical_o, map_illegal_o, port_count_o};
            3'h4: return {plus_pin_o, plus_pin_oe_o, minus_pin_o, minus_pin_oe_o};
            default: return {8'h00, dpos_in_o, dneg_in_o};
        endcase
    endfunction

    function automatic logic [2:0] nib(input logic [3:0] n, input logic [1:0] phys);
        if (!logical_mapping_enable_i) return {1'b1, phys};
        if (n == 4'h0 || n > `MAX_LOGICAL) return 3'h0;
        return {1'b1, n[1:0]};
    endfunction

    task automatic note(input logic [2:0] sel, input logic [15:0] exp);
        sel_q.push_back(sel);
        exp_q.push_back(exp);
        ->sample_ev;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic wr(input cfg_byte_t a, input cfg_byte_t d);
        @(negedge ref_clk_i);
        cfg_addr_i = a;
        cfg_wdata_i = d;
        cfg_wr_i = 1'b1;
        @(negedge ref_clk_i);
        cfg_wr_i = 1'b0;
        if (a == `PIN_POLARITY_EXCHANGE_OFS) exch = d[3:0];
        if (a == `PORT_ONE_TWO_LOGICAL_MAP_OFS) map = d;
    endtask

    task automatic check_regs();
        logic [2:0] f1, f2;
        logic [7:0] rd;
        f1 = nib(map[3:0], 2'h1);
        f2 = nib(map[7:4], 2'h2);
        rd = (cfg_addr_i == `PIN_POLARITY_EXCHANGE_OFS) ? {4'h0, exch} : 8'h00;
        if (cfg_addr_i == `PORT_ONE_TWO_LOGICAL_MAP_OFS) rd = map;
        note(3'h0, {12'h000, exch});
        note(3'h1, {8'h00, map});
        note(3'h2, {8'h00, rd});
        note(3'h3, {7'h00, f1, f2, logical_mapping_enable_i & (map[3:0] > 4'h3 | map[7:4] > 4'h3),
            {1'b0, f1[2]} + {1'b0, f2[2]} + {1'b0, port3_enabled_i}});
    endtask

    task automatic check_pins();
        logic [3:0] po, poe, mo, moe, pw, mw;
        po = (exch & dneg_out_i) | (~exch & dpos_out_i);
        poe = (exch & dneg_oe_i) | (~exch & dpos_oe_i);
        mo = (exch & dpos_out_i) | (~exch & dneg_out_i);
        moe = (exch & dpos_oe_i) | (~exch & dneg_oe_i);
        pw = (poe & po) | (~poe & far_oe & far_p);
        mw = (moe & mo) | (~moe & far_oe & far_m);
        note(3'h4, {po, poe, mo, moe});
        note(3'h5, {8'h00, (exch & mw) | (~exch & pw), (exch & pw) | (~exch & mw)});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        forever begin
            @(sample_ev);
            while (sel_q.size() > 0) begin
                mon_sel = sel_q.pop_front();
                mon_exp = exp_q.pop_front();
                samples_checked++;
                if (observe(mon_sel) !== mon_exp) begin
                    err_total++;
                    $display("wrong value t=%0t exp=%h got=%h", $time, mon_exp, observe(mon_sel));
                end
            end
        end
    end

    // The whole sequence needs well under a thousand cycles.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            results();
        end
    end

    initial begin
        seed = 95271;
        {rst_n_i, cfg_wr_i, logical_mapping_enable_i, port3_enabled_i} = 4'h0;
        {cfg_addr_i, cfg_wdata_i, dpos_out_i, dpos_oe_i, dneg_out_i, dneg_oe_i} = 32'h0;
        {far_p, far_m, far_oe} = 12'h000;
        tick(8);
        rst_n_i = 1'b1;
        exch = `PIN_POLARITY_EXCHANGE_RST;
        map = `PORT_ONE_TWO_LOGICAL_MAP_RST;
        cfg_addr_i = `PIN_POLARITY_EXCHANGE_OFS;
        tick(3);
        check_regs();
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            wr(adr[i % 4], 8'($random(seed)));
            tick(3);
            check_regs();
        end
        $display("test exchange register done");
        for (int i = 0; i < 16; i++) begin
            logical_mapping_enable_i = i[3];
            port3_enabled_i = 1'($random(seed));
            wr(`PORT_ONE_TWO_LOGICAL_MAP_OFS, maps[i % 8]);
            tick(3);
            check_regs();
        end
        $display("test logical map done");
        for (int i = 0; i < 16; i++) begin
            wr(`PIN_POLARITY_EXCHANGE_OFS, {4'h0, 4'($random(seed))});
            {dpos_out_i, dpos_oe_i, dneg_out_i, dneg_oe_i} = 16'($random(seed));
            {far_p, far_m, far_oe} = 12'($random(seed));
            tick(5);
            check_pins();
        end
        $display("test pin exchange done");
        rst_n_i = 1'b0;
        tick(2);
        rst_n_i = 1'b1;
        exch = `PIN_POLARITY_EXCHANGE_RST;
        map = `PORT_ONE_TWO_LOGICAL_MAP_RST;
        tick(3);
        check_regs();
        $display("test second reset done");
        tick(1);
        results();
    end
endmodule

// ==== hdl/pin_exchange_lane.sv ====
module pin_exchange_lane (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic swap_i,
    // Core side
    input wire logic dpos_out_i,
    input wire logic dpos_oe_i,
    input wire logic dneg_out_i,
    input wire logic dneg_oe_i,
    output logic dpos_in_o,
    output logic dneg_in_o,
    // Pin side
    input wire logic plus_pin_i,
    output logic plus_pin_o,
    output logic plus_pin_oe_o,
    input wire logic minus_pin_i,
    output logic minus_pin_o,
    output logic minus_pin_oe_o
);
    import usb_swap_pkg::*;

    typedef struct packed {
        logic plus_m;
        logic plus_s;
        logic minus_m;
        logic minus_s;
        logic plus_o;
        logic plus_oe;
        logic minus_o;
        logic minus_oe;
        logic dpos_in;
        logic dneg_in;
    } lane_state_t;

    lane_state_t s_q;
    lane_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.plus_m = plus_pin_i;
        s_d.plus_s = s_q.plus_m;
        s_d.minus_m = minus_pin_i;
        s_d.minus_s = s_q.minus_m;
        if (swap_i) begin
            s_d.plus_o = dneg_out_i;
            s_d.plus_oe = dneg_oe_i;
            s_d.minus_o = dpos_out_i;
            s_d.minus_oe = dpos_oe_i;
            s_d.dpos_in = s_q.minus_s;
            s_d.dneg_in = s_q.plus_s;
        end else begin
            s_d.plus_o = dpos_out_i;
            s_d.plus_oe = dpos_oe_i;
            s_d.minus_o = dneg_out_i;
            s_d.minus_oe = dneg_oe_i;
            s_d.dpos_in = s_q.plus_s;
            s_d.dneg_in = s_q.minus_s;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign plus_pin_o = s_q.plus_o;
    assign plus_pin_oe_o = s_q.plus_oe;
    assign minus_pin_o = s_q.minus_o;
    assign minus_pin_oe_o = s_q.minus_oe;
    assign dpos_in_o = s_q.dpos_in;
    assign dneg_in_o = s_q.dneg_in;

    property p_straight_route;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !swap_i |=> (plus_pin_o == $past(dpos_out_i)) && (minus_pin_o == $past(dneg_out_i));
    endproperty
    a_straight_route: assert property (p_straight_route) else $error("straight routing broken");

    property p_swapped_route;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        swap_i |=> (plus_pin_o == $past(dneg_out_i)) && (minus_pin_oe_o == $past(dpos_oe_i));
    endproperty
    a_swapped_route: assert property (p_swapped_route) else $error("swapped routing broken");

    property p_swapped_receive;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        swap_i ##1 swap_i ##1 swap_i |=> dpos_in_o == $past(minus_pin_i, 3);
    endproperty
    a_swapped_receive: assert property (p_swapped_receive) else $error("receive swap broken");
endmodule

// ==== hdl/usb_port_swap_remap_config.sv ====
`include "usb_swap_params.svh"

module usb_port_swap_remap_config (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Configuration port from the loader or the serial slave
    input wire usb_swap_pkg::cfg_byte_t cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire usb_swap_pkg::cfg_byte_t cfg_wdata_i,
    output usb_swap_pkg::cfg_byte_t cfg_rdata_o,
    // Mode and neighbouring configuration
    input wire logic logical_mapping_enable_i,
    input wire logic port3_enabled_i,
    // Port numbering towards the hub core
    output logic port1_enabled_o,
    output usb_swap_pkg::logical_num_t port1_logical_o,
    output logic port2_enabled_o,
    output usb_swap_pkg::logical_num_t port2_logical_o,
    output logic map_illegal_o,
    output logic [1:0] port_count_o,
    // Register contents
    output logic [`XCHG_USED_W-1:0] pin_exchange_bits_o,
    output usb_swap_pkg::cfg_byte_t port_one_two_map_field_o,
    // Core side of each pin pair, index 0 is upstream
    input wire logic [`PIN_PAIRS-1:0] dpos_out_i,
    input wire logic [`PIN_PAIRS-1:0] dpos_oe_i,
    input wire logic [`PIN_PAIRS-1:0] dneg_out_i,
    input wire logic [`PIN_PAIRS-1:0] dneg_oe_i,
    output logic [`PIN_PAIRS-1:0] dpos_in_o,
    output logic [`PIN_PAIRS-1:0] dneg_in_o,
    // Pins
    input wire logic [`PIN_PAIRS-1:0] plus_pin_i,
    output logic [`PIN_PAIRS-1:0] plus_pin_o,
    output logic [`PIN_PAIRS-1:0] plus_pin_oe_o,
    input wire logic [`PIN_PAIRS-1:0] minus_pin_i,
    output logic [`PIN_PAIRS-1:0] minus_pin_o,
    output logic [`PIN_PAIRS-1:0] minus_pin_oe_o
);
    import usb_swap_pkg::*;

    typedef struct packed {
        logic [`XCHG_USED_W-1:0] xchg;
        cfg_byte_t map;
        cfg_byte_t rdata;
        map_entry_t p1;
        map_entry_t p2;
        logic illegal;
        logic [1:0] count;
    } cfg_state_t;

    cfg_state_t s_q;
    cfg_state_t s_d;

    // Values above the largest logical number disable the port rather than alias
    // onto a legal number, so a bad image cannot collide two ports.
    function automatic map_entry_t decode_field(input logic [`MAP_FIELD_W-1:0] f);
        map_entry_t e;
        e.enabled = (f != 4'h0) && (f <= `MAX_LOGICAL);
        e.illegal = f > `MAX_LOGICAL;
        e.num = e.enabled ? f[1:0] : 2'h0;
        return e;
    endfunction

    map_entry_t dec1;
    map_entry_t dec2;

    always_comb begin
        s_d = s_q;
        if (cfg_wr_i && cfg_addr_i == `PIN_POLARITY_EXCHANGE_OFS) begin
            s_d.xchg[`XCHG_UPSTREAM_BIT] = cfg_wdata_i[`XCHG_UPSTREAM_BIT];
            s_d.xchg[`XCHG_PORT1_BIT] = cfg_wdata_i[`XCHG_PORT1_BIT];
            s_d.xchg[`XCHG_PORT2_BIT] = cfg_wdata_i[`XCHG_PORT2_BIT];
            s_d.xchg[`XCHG_PORT3_BIT] = cfg_wdata_i[`XCHG_PORT3_BIT];
        end
        if (cfg_wr_i && cfg_addr_i == `PORT_ONE_TWO_LOGICAL_MAP_OFS) begin
            s_d.map = cfg_wdata_i;
        end
        // Reserved exchange bits are not stored and read back as zero.
        unique case (cfg_addr_i)
            `PIN_POLARITY_EXCHANGE_OFS: s_d.rdata = {4'h0, s_q.xchg};
            `PORT_ONE_TWO_LOGICAL_MAP_OFS: s_d.rdata = s_q.map;
            default: s_d.rdata = 8'h00;
        endcase
        dec1 = decode_field(s_q.map[`MAP_PORT1_LSB +: `MAP_FIELD_W]);
        dec2 = decode_field(s_q.map[`MAP_PORT2_LSB +: `MAP_FIELD_W]);
        if (logical_mapping_enable_i) begin
            s_d.p1 = dec1;
            s_d.p2 = dec2;
            s_d.illegal = dec1.illegal | dec2.illegal;
        end else begin
            s_d.p1 = '{enabled: 1'b1, illegal: 1'b0, num: 2'h1};
            s_d.p2 = '{enabled: 1'b1, illegal: 1'b0, num: 2'h2};
            s_d.illegal = 1'b0;
        end
        // Only the count leaves the hub; the numbering goes to the hub core.
        s_d.count = 2'({1'b0, s_d.p1.enabled} + {1'b0, s_d.p2.enabled}
                    + {1'b0, port3_enabled_i});
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.xchg <= `PIN_POLARITY_EXCHANGE_RST;
            s_q.map <= `PORT_ONE_TWO_LOGICAL_MAP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg_rdata_o = s_q.rdata;
    assign port1_enabled_o = s_q.p1.enabled;
    assign port1_logical_o = s_q.p1.num;
    assign port2_enabled_o = s_q.p2.enabled;
    assign port2_logical_o = s_q.p2.num;
    assign map_illegal_o = s_q.illegal;
    assign port_count_o = s_q.count;
    assign pin_exchange_bits_o = s_q.xchg;
    assign port_one_two_map_field_o = s_q.map;

    genvar gi;
    generate
        for (gi = 0; gi < `PIN_PAIRS; gi++) begin : g_lane
            pin_exchange_lane u_lane (
                .ref_clk_i(ref_clk_i),
                .rst_n_i(rst_n_i),
                .swap_i(s_q.xchg[gi]),
                .dpos_out_i(dpos_out_i[gi]),
                .dpos_oe_i(dpos_oe_i[gi]),
                .dneg_out_i(dneg_out_i[gi]),
                .dneg_oe_i(dneg_oe_i[gi]),
                .dpos_in_o(dpos_in_o[gi]),
                .dneg_in_o(dneg_in_o[gi]),
                .plus_pin_i(plus_pin_i[gi]),
                .plus_pin_o(plus_pin_o[gi]),
                .plus_pin_oe_o(plus_pin_oe_o[gi]),
                .minus_pin_i(minus_pin_i[gi]),
                .minus_pin_o(minus_pin_o[gi]),
                .minus_pin_oe_o(minus_pin_oe_o[gi])
            );
        end
    endgenerate

    property p_upstream_bit;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_wr_i && cfg_addr_i == 8'hFA |=> pin_exchange_bits_o[0] == $past(cfg_wdata_i[0]);
    endproperty
    a_upstream_bit: assert property (p_upstream_bit) else $error("upstream bit not stored");

    property p_port1_bit;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_wr_i && cfg_addr_i == 8'hFA ##1 !dpos_out_i[1] && dneg_out_i[1]
        |=> plus_pin_o[1] == $past(pin_exchange_bits_o[1]);
    endproperty
    a_port1_bit: assert property (p_port1_bit) else $error("port 1 exchange wrong");

    property p_port2_bit;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_wr_i && cfg_addr_i == 8'hFA |=> pin_exchange_bits_o[2] == $past(cfg_wdata_i[2]);
    endproperty
    a_port2_bit: assert property (p_port2_bit) else $error("port 2 bit not stored");

    property p_port3_bit;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_wr_i && cfg_addr_i == 8'hFA |=> pin_exchange_bits_o[3] == $past(cfg_wdata_i[3]);
    endproperty
    a_port3_bit: assert property (p_port3_bit) else $error("port 3 bit not stored");

    property p_reserved_zero;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_addr_i == 8'hFA && !cfg_wr_i |=> cfg_rdata_o[7:4] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_physical_order;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !logical_mapping_enable_i |=> port1_logical_o == 2'h1 && port2_logical_o == 2'h2
            && port1_enabled_o && port2_enabled_o;
    endproperty
    a_physical_order: assert property (p_physical_order) else $error("physical order lost");

    property p_port_count;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 port_count_o == 2'($past(port3_enabled_i)) + 2'(port1_enabled_o) + 2'(port2_enabled_o);
    endproperty
    a_port_count: assert property (p_port_count) else $error("port count wrong");

    property p_port1_field;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        logical_mapping_enable_i && port_one_two_map_field_o[3:0] > 4'h3
        |=> !port1_enabled_o && map_illegal_o;
    endproperty
    a_port1_field: assert property (p_port1_field) else $error("illegal port 1 value used");

    property p_port2_field;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        logical_mapping_enable_i && port_one_two_map_field_o[7:4] == 4'h1
        |=> port2_enabled_o && port2_logical_o == 2'h1;
    endproperty
    a_port2_field: assert property (p_port2_field) else $error("port 2 not on logical 1");

    property p_map_stored;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_wr_i && cfg_addr_i == 8'hFB |=> port_one_two_map_field_o == $past(cfg_wdata_i);
    endproperty
    a_map_stored: assert property (p_map_stored) else $error("map byte not stored");

    // Writes to any other offset, the neighbouring remap register included, must not leak
    // into these two registers.
    property p_exchange_held;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !(cfg_wr_i && cfg_addr_i == 8'hFA) |=> $stable(pin_exchange_bits_o);
    endproperty
    a_exchange_held: assert property (p_exchange_held) else $error("exchange bits moved");

    property p_map_held;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !(cfg_wr_i && cfg_addr_i == 8'hFB) |=> $stable(port_one_two_map_field_o);
    endproperty
    a_map_held: assert property (p_map_held) else $error("map byte moved");

    property p_exchange_read;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_addr_i == 8'hFA |=> cfg_rdata_o == {4'h0, $past(pin_exchange_bits_o)};
    endproperty
    a_exchange_read: assert property (p_exchange_read) else $error("exchange read wrong");

    property p_map_read;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_addr_i == 8'hFB |=> cfg_rdata_o == $past(port_one_two_map_field_o);
    endproperty
    a_map_read: assert property (p_map_read) else $error("map read wrong");

    property p_port1_mapped;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        logical_mapping_enable_i && port_one_two_map_field_o[3:0] != 4'h0
            && port_one_two_map_field_o[3:0] <= 4'h3
        |=> port1_enabled_o && port1_logical_o == $past(port_one_two_map_field_o[1:0]);
    endproperty
    a_port1_mapped: assert property (p_port1_mapped) else $error("port 1 number wrong");

    property p_port1_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        logical_mapping_enable_i && port_one_two_map_field_o[3:0] == 4'h0
        |=> !port1_enabled_o && port1_logical_o == 2'h0;
    endproperty
    a_port1_off: assert property (p_port1_off) else $error("port 1 not disabled");

    property p_port2_mapped;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        logical_mapping_enable_i && port_one_two_map_field_o[7:4] != 4'h0
            && port_one_two_map_field_o[7:4] <= 4'h3
        |=> port2_enabled_o && port2_logical_o == $past(port_one_two_map_field_o[5:4]);
    endproperty
    a_port2_mapped: assert property (p_port2_mapped) else $error("port 2 number wrong");

    property p_port2_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        logical_mapping_enable_i && port_one_two_map_field_o[7:4] == 4'h0
        |=> !port2_enabled_o && port2_logical_o == 2'h0;
    endproperty
    a_port2_off: assert property (p_port2_off) else $error("port 2 not disabled");

    property p_port2_refused;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        logical_mapping_enable_i && port_one_two_map_field_o[7:4] > 4'h3
        |=> !port2_enabled_o && map_illegal_o;
    endproperty
    a_port2_refused: assert property (p_port2_refused) else $error("port 2 not refused");

    property p_illegal_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !logical_mapping_enable_i |=> !map_illegal_o;
    endproperty
    a_illegal_off: assert property (p_illegal_off) else $error("illegal flag raised");

    // A core driving D+ low and D- high shows the lane's routing directly on the pins.
    property p_upstream_route;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !dpos_out_i[0] && dneg_out_i[0]
        |=> plus_pin_o[0] == $past(pin_exchange_bits_o[0]) && minus_pin_o[0] != plus_pin_o[0];
    endproperty
    a_upstream_route: assert property (p_upstream_route) else $error("upstream misrouted");

    property p_port2_route;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !dpos_out_i[2] && dneg_out_i[2]
        |=> plus_pin_o[2] == $past(pin_exchange_bits_o[2]) && minus_pin_o[2] != plus_pin_o[2];
    endproperty
    a_port2_route: assert property (p_port2_route) else $error("port 2 misrouted");

    property p_port3_route;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !dpos_out_i[3] && dneg_out_i[3]
        |=> plus_pin_o[3] == $past(pin_exchange_bits_o[3]) && minus_pin_o[3] != plus_pin_o[3];
    endproperty
    a_port3_route: assert property (p_port3_route) else $error("port 3 misrouted");
endmodule

// ==== hdl/usb_swap_params.svh ====
`ifndef USB_SWAP_PARAMS_SVH
`define USB_SWAP_PARAMS_SVH

// Register offsets on the byte-wide configuration port.
`define PIN_POLARITY_EXCHANGE_OFS 8'hFA
`define PORT_ONE_TWO_LOGICAL_MAP_OFS 8'hFB

// Reset values.
`define PIN_POLARITY_EXCHANGE_RST 4'h0
`define PORT_ONE_TWO_LOGICAL_MAP_RST 8'h00

// Field positions in the exchange register.
`define XCHG_UPSTREAM_BIT 0
`define XCHG_PORT1_BIT 1
`define XCHG_PORT2_BIT 2
`define XCHG_PORT3_BIT 3
`define XCHG_USED_W 4

// Field positions in the map register.
`define MAP_PORT1_LSB 0
`define MAP_PORT2_LSB 4
`define MAP_FIELD_W 4

// Number of pin pairs, upstream included, and the largest legal logical number.
`define PIN_PAIRS 4
`define MAX_LOGICAL 4'h3

`endif

// ==== hdl/usb_swap_pkg.sv ====
package usb_swap_pkg;

    typedef logic [7:0] cfg_byte_t;
    typedef logic [1:0] logical_num_t;

    typedef struct packed {
        logic enabled;
        logic illegal;
        logical_num_t num;
    } map_entry_t;

endpackage
